// ==== shared/seq_map.svh ====
// Register offsets, field positions, reset values and timing constants of the step sequencer.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL       12'h000
`define ADDR_MAX_FREQ   12'h004
`define ADDR_RATED_VOLT 12'h008
`define ADDR_STATUS     12'h00C
`define ADDR_ELAPSED    12'h010
`define ADDR_PF_SNAP    12'h014
`define ADDR_REF_BASE   12'h040
`define ADDR_TIME_BASE  12'h080
`define ADDR_STEP_SPAN  12'h040
// ----------------------------------------
// Control and step-time field positions
// ----------------------------------------
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_PWR_RET    2
`define CTRL_STOP_RET   3
`define CTRL_SRC_VOLT   4
`define CTRL_UNIT_HOURS 5
`define RAMP_LO         16
`define RAMP_HI         17
// ----------------------------------------
// Ranges and reset values
// ----------------------------------------
`define REF_FULL        16'sd1000
`define REF_FULL_SCALE  32'd1000
`define DUR_MAX         16'd65000
`define MAX_FREQ_RST    16'h1388
`define RATED_VOLT_RST  16'h0DC0
`define LAST_STEP       4'hF
`define FIRST_STEP      4'h0
// ----------------------------------------
// Time base
// ----------------------------------------
`define CLK_PERIOD_NS   10
`define TENTH_SEC_NS    100000000
`define TENTHS_PER_HOUR_TENTH 12'd3600
`endif

// ==== shared/seq_pkg.sv ====
// Types shared by the step sequencer and its testbench.
package seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b11
  } seq_state_t;
  typedef enum logic [1:0] {
    END_STOP   = 2'b00,
    END_HOLD   = 2'b01,
    END_REPEAT = 2'b10
  } end_mode_t;
endpackage

// ==== hw/step_tick_gen.sv ====
// Time base: one pulse per tenth of a second, or per tenth of an hour.
`timescale 1ns/1ns
`include "seq_map.svh"
module step_tick_gen #(
  parameter int unsigned TENTH_SEC_CYCLES = `TENTH_SEC_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic unitHours,
  // Result
  output logic      tick
);
  logic [31:0] cycleCnt_r;
  logic [11:0] tenthCnt_r;
  logic        secTick;

  assign secTick = enable && (cycleCnt_r == 32'(TENTH_SEC_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleCnt_r <= 32'h0;
    end else if (!enable || secTick) begin
      cycleCnt_r <= 32'h0;
    end else begin
      cycleCnt_r <= cycleCnt_r + 32'h1;
    end
  end

  // A tenth of an hour is counted as 3600 tenth-second pulses so the wide count stays small.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tenthCnt_r <= 12'h0;
    end else if (!enable || !unitHours) begin
      tenthCnt_r <= 12'h0;
    end else if (secTick) begin
      tenthCnt_r <= (tenthCnt_r == `TENTHS_PER_HOUR_TENTH - 12'h1) ? 12'h0 : tenthCnt_r + 12'h1;
    end
  end

  assign tick = secTick && (!unitHours || tenthCnt_r == `TENTHS_PER_HOUR_TENTH - 12'h1);
endmodule

// ==== hw/multistep_speed_sequencer.sv ====
// Multi-step speed sequencer with APB register access and retention of the step position.
`timescale 1ns/1ns
`include "seq_map.svh"
module multistep_speed_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned TENTH_SEC_CYCLES = `TENTH_SEC_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive command pins
  input  wire logic        runReq,
  input  wire logic        powerFail,
  input  wire logic        powerUp,
  // Setpoint path
  output logic      [15:0] freqSet,
  output logic             reverse,
  output logic      [15:0] voltSet,
  output logic      [1:0]  rampSel,
  output logic             driveRun
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] scaleRef(input logic signed [15:0] refVal, input logic [15:0] full);
    logic [31:0] mag;
    mag = 32'(refVal[15] ? -refVal : refVal);
    return 16'((mag * 32'(full)) / `REF_FULL_SCALE);
  endfunction

  function automatic logic signed [15:0] clampRef(input logic signed [15:0] v);
    return (v > `REF_FULL) ? `REF_FULL : ((v < -`REF_FULL) ? -`REF_FULL : v);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] runSync_r;
  logic [2:0] pfSync_r;
  logic [2:0] upSync_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runSync_r <= 3'h0;
      pfSync_r  <= 3'h0;
      upSync_r  <= 3'h0;
    end else begin
      runSync_r <= {runSync_r[1:0], runReq};
      pfSync_r  <= {pfSync_r[1:0], powerFail};
      upSync_r  <= {upSync_r[1:0], powerUp};
    end
  end

  logic startEv;
  logic stopEv;
  logic pfRise;
  logic upRise;
  assign startEv = runSync_r[1] && !runSync_r[2];
  assign stopEv  = !runSync_r[1] && runSync_r[2];
  assign pfRise  = pfSync_r[1] && !pfSync_r[2];
  assign upRise  = upSync_r[1] && !upSync_r[2];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [5:0]         ctrl_r;
  logic [15:0]        maxFreq_r;
  logic [15:0]        ratedVolt_r;
  logic signed [15:0] stepRef_r  [16];
  logic [15:0]        stepDur_r  [16];
  logic [1:0]         stepRamp_r [16];
  end_mode_t endMode;
  logic      pwrRetain;
  logic      stopRetain;
  logic      srcVolt;
  assign endMode    = end_mode_t'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign pwrRetain  = ctrl_r[`CTRL_PWR_RET];
  assign stopRetain = ctrl_r[`CTRL_STOP_RET];
  assign srcVolt    = ctrl_r[`CTRL_SRC_VOLT];
  logic       wrEn;
  logic       rdEn;
  logic       refHit;
  logic       timeHit;
  logic [3:0] stepSel;
  assign wrEn    = psel && penable && pwrite && pready;
  assign rdEn    = psel && penable && !pwrite && !pready;
  assign refHit  = paddr >= `ADDR_REF_BASE && paddr < `ADDR_REF_BASE + `ADDR_STEP_SPAN && paddr[1:0] == 2'h0;
  assign timeHit = paddr >= `ADDR_TIME_BASE && paddr < `ADDR_TIME_BASE + `ADDR_STEP_SPAN && paddr[1:0] == 2'h0;
  assign stepSel = paddr[5:2];
  // Mode code 3 is not defined, so a write of it falls back to the stop mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r      <= 6'h00;
      maxFreq_r   <= `MAX_FREQ_RST;
      ratedVolt_r <= `RATED_VOLT_RST;
    end else if (wrEn && paddr == `ADDR_CTRL) begin
      ctrl_r <= {pwdata[`CTRL_UNIT_HOURS:`CTRL_PWR_RET],
                 (pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO] == 2'h3) ? 2'h0 : pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]};
    end else if (wrEn && paddr == `ADDR_MAX_FREQ) begin
      maxFreq_r <= pwdata[15:0];
    end else if (wrEn && paddr == `ADDR_RATED_VOLT) begin
      ratedVolt_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        stepRef_r[i]  <= 16'sh0000;
        stepDur_r[i]  <= 16'h0000;
        stepRamp_r[i] <= 2'h0;
      end
    end else if (wrEn && refHit) begin
      stepRef_r[stepSel] <= clampRef(pwdata[15:0]);
    end else if (wrEn && timeHit) begin
      stepDur_r[stepSel]  <= (pwdata[15:0] > `DUR_MAX) ? `DUR_MAX : pwdata[15:0];
      stepRamp_r[stepSel] <= pwdata[`RAMP_HI:`RAMP_LO];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_t  state_r;
  logic [3:0]  idx_r;
  logic [15:0] elapsed_r;
  logic [3:0]  pfIdx_r;
  logic [15:0] pfElapsed_r;
  logic [15:0] pfFreq_r;
  logic        resumeValid_r;
  logic        tick;
  logic        stepDone;
  logic        lastDone;
  step_tick_gen #(.TENTH_SEC_CYCLES(TENTH_SEC_CYCLES)) u_tick (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (state_r == ST_RUN),
    .unitHours (ctrl_r[`CTRL_UNIT_HOURS]),
    .tick      (tick)
  );
  assign stepDone = state_r == ST_RUN && elapsed_r >= stepDur_r[idx_r];
  assign lastDone = stepDone && idx_r == `LAST_STEP;
  // A stop outranks the end of a pass, so a stop in that cycle is never lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      idx_r     <= `FIRST_STEP;
      elapsed_r <= 16'h0;
    end else if (upRise) begin
      state_r   <= ST_IDLE;
      idx_r     <= pwrRetain ? pfIdx_r : `FIRST_STEP;
      elapsed_r <= pwrRetain ? pfElapsed_r : 16'h0;
    end else if (stopEv && state_r != ST_IDLE) begin
      state_r <= ST_IDLE;
    end else if (startEv && state_r == ST_IDLE) begin
      state_r <= ST_RUN;
      if (!stopRetain && !resumeValid_r) begin
        idx_r     <= `FIRST_STEP;
        elapsed_r <= 16'h0;
      end
    end else if (lastDone) begin
      elapsed_r <= 16'h0;
      if (srcVolt || endMode == END_REPEAT) begin
        idx_r <= `FIRST_STEP;
      end else if (endMode == END_HOLD) begin
        state_r <= ST_HOLD;
      end else begin
        state_r <= ST_IDLE;
        idx_r   <= `FIRST_STEP;
      end
    end else if (stepDone) begin
      idx_r     <= idx_r + 4'h1;
      elapsed_r <= 16'h0;
    end else if (tick && elapsed_r != 16'hFFFF) begin
      elapsed_r <= elapsed_r + 16'h1;
    end
  end

  // Power-up with retention lets the next start resume even when stop retention is off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeValid_r <= 1'b0;
    end else if (upRise) begin
      resumeValid_r <= pwrRetain;
    end else if (startEv && state_r == ST_IDLE) begin
      resumeValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pfIdx_r     <= `FIRST_STEP;
      pfElapsed_r <= 16'h0;
      pfFreq_r    <= 16'h0;
    end else if (pfRise) begin
      pfIdx_r     <= idx_r;
      pfElapsed_r <= elapsed_r;
      pfFreq_r    <= freqSet;
    end
  end

  // ----------------------------------------
  // Setpoint outputs
  // ----------------------------------------
  logic active;
  assign active = state_r != ST_IDLE;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freqSet  <= 16'h0;
      reverse  <= 1'b0;
      voltSet  <= 16'h0;
      rampSel  <= 2'h0;
      driveRun <= 1'b0;
    end else begin
      freqSet  <= (active && !srcVolt) ? scaleRef(stepRef_r[idx_r], maxFreq_r) : 16'h0;
      reverse  <= active && !srcVolt && stepRef_r[idx_r][15];
      voltSet  <= (active && srcVolt) ? scaleRef(stepRef_r[idx_r], ratedVolt_r) : 16'h0;
      rampSel  <= stepRamp_r[idx_r];
      driveRun <= active;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // One wait state keeps prdata and pready straight from flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && penable && !pready) begin
        if (refHit) begin
          prdata <= rdEn ? {{16{stepRef_r[stepSel][15]}}, stepRef_r[stepSel]} : 32'h0;
        end else if (timeHit) begin
          prdata <= rdEn ? {14'h0, stepRamp_r[stepSel], stepDur_r[stepSel]} : 32'h0;
        end else if (paddr == `ADDR_CTRL) begin
          prdata <= rdEn ? {26'h0, ctrl_r} : 32'h0;
        end else if (paddr == `ADDR_MAX_FREQ) begin
          prdata <= rdEn ? {16'h0, maxFreq_r} : 32'h0;
        end else if (paddr == `ADDR_RATED_VOLT) begin
          prdata <= rdEn ? {16'h0, ratedVolt_r} : 32'h0;
        end else if (paddr == `ADDR_STATUS && !pwrite) begin
          prdata <= {24'h0, resumeValid_r, reverse, state_r, idx_r};
        end else if (paddr == `ADDR_ELAPSED && !pwrite) begin
          prdata <= {16'h0, elapsed_r};
        end else if (paddr == `ADDR_PF_SNAP && !pwrite) begin
          prdata <= {12'h0, pfIdx_r, pfFreq_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dir;
    (state_r == ST_RUN && !srcVolt) |=> (reverse == $past(stepRef_r[idx_r][15]));
  endproperty
  a_dir: assert property (p_dir) else $error("Direction does not follow reference sign.");
  property p_mode_stop;
    (lastDone && !stopEv && !upRise && !srcVolt && endMode == END_STOP) |=> (state_r == ST_IDLE) ##1 !driveRun;
  endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("Stop mode did not stop after pass.");
  property p_mode_hold;
    (lastDone && !stopEv && !upRise && !srcVolt && endMode == END_HOLD) |=> (state_r == ST_HOLD && idx_r == `LAST_STEP);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("Hold mode left the final step.");
  property p_repeat;
    (lastDone && !stopEv && !upRise && (srcVolt || endMode == END_REPEAT)) |=> (state_r == ST_RUN && idx_r == `FIRST_STEP);
  endproperty
  a_repeat: assert property (p_repeat) else $error("Sequence did not restart at first step.");
  property p_pf_store;
    pfRise |=> (pfIdx_r == $past(idx_r) && pfElapsed_r == $past(elapsed_r));
  endproperty
  a_pf_store: assert property (p_pf_store) else $error("Power-fail snapshot not taken.");
  property p_pwr_up;
    upRise |=> (idx_r == ($past(pwrRetain) ? $past(pfIdx_r) : `FIRST_STEP));
  endproperty
  a_pwr_up: assert property (p_pwr_up) else $error("Power-up position wrong.");
  property p_stop_keep;
    (stopEv && !upRise && state_r != ST_IDLE) |=> (state_r == ST_IDLE && idx_r == $past(idx_r));
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("Stop did not keep the position.");
  property p_start_first;
    (startEv && !upRise && !stopEv && state_r == ST_IDLE && !stopRetain && !resumeValid_r)
      |=> (idx_r == `FIRST_STEP && elapsed_r == 16'h0);
  endproperty
  a_start_first: assert property (p_start_first) else $error("Start did not begin at first step.");
  property p_ramp;
    (state_r == ST_RUN) |=> (rampSel == $past(stepRamp_r[idx_r]));
  endproperty
  a_ramp: assert property (p_ramp) else $error("Ramp set does not follow step.");
  property p_dur_range;
    (wrEn && timeHit) |=> (stepDur_r[$past(stepSel)] <= `DUR_MAX);
  endproperty
  a_dur_range: assert property (p_dur_range) else $error("Step duration above range.");
  property p_advance;
    (stepDone && !lastDone && !stopEv && !upRise) |=> (idx_r == $past(idx_r) + 4'h1 && elapsed_r == 16'h0);
  endproperty
  a_advance: assert property (p_advance) else $error("Step did not advance at duration.");
endmodule

// ==== tb/drive_side_model.sv ====
// Drive-side model: run/stop and power pins, and the signed speed the drive would apply.
`timescale 1ns/1ns
module drive_side_model (
  // Clock
  input  wire logic        clk,
  // Pins towards the sequencer
  output logic             runReq,
  output logic             powerFail,
  output logic             powerUp,
  // Setpoint from the sequencer
  input  wire logic [15:0] freqSet,
  input  wire logic        reverse,
  input  wire logic        driveRun
);
  logic [31:0] speed;

  initial begin
    runReq = 1'b0;
    powerFail = 1'b0;
    powerUp = 1'b0;
  end

  // A stopped drive applies no speed, whatever the setpoint shows.
  always_ff @(posedge clk) begin
    speed <= !driveRun ? 32'h0 : reverse ? 32'h0 - {16'h0, freqSet} : {16'h0, freqSet};
  end

  // Pins pass two sync flops inside, so every level is held well past that delay.
  task automatic setRun(input logic v);
    @(posedge clk);
    runReq <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse(input bit up);
    @(posedge clk);
    if (up) powerUp <= 1'b1;
    else powerFail <= 1'b1;
    repeat (3) @(posedge clk);
    powerUp <= 1'b0;
    powerFail <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ==== tb/multistep_speed_sequencer_tb.sv ====
// Self-checking bench for the multi-step speed sequencer.
`timescale 1ns/1ns
`include "seq_map.svh"
module multistep_speed_sequencer_tb
  import seq_pkg::*;
;
  logic               clk;
  logic               rst_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic        [11:0] paddr;
  logic        [31:0] pwdata;
  logic        [31:0] prdata;
  logic               pready;
  logic               pslverr;
  wire logic          runReq;
  wire logic          powerFail;
  wire logic          powerUp;
  logic        [15:0] freqSet;
  logic               reverse;
  logic        [15:0] voltSet;
  logic        [1:0]  rampSel;
  logic               driveRun;
  int                 failures = 0;
  int                 compares = 0;
  int                 cycles = 0;
  int                 seed = 58;
  logic signed [15:0] refs [16];
  logic        [1:0]  ramps [16];
  logic        [15:0] maxF;
  logic        [31:0] q;
  logic               e;
  logic        [3:0]  st0;
  logic        [3:0]  st1;
  logic        [1:0]  s;

  multistep_speed_sequencer #(
    .TENTH_SEC_CYCLES(10)
  ) u_dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .runReq    (runReq),
    .powerFail (powerFail),
    .powerUp   (powerUp),
    .freqSet   (freqSet),
    .reverse   (reverse),
    .voltSet   (voltSet),
    .rampSel   (rampSel),
    .driveRun  (driveRun)
  );

  drive_side_model u_drive (
    .clk       (clk),
    .runReq    (runReq),
    .powerFail (powerFail),
    .powerUp   (powerUp),
    .freqSet   (freqSet),
    .reverse   (reverse),
    .driveRun  (driveRun)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // A bus edge between transfers keeps psel from being written twice in one step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic status;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    st0 = q[3:0];
    s = q[5:4];
  endtask

  task automatic progDur(input logic [15:0] d);
    for (int i = 0; i < 16; i++) apb(1'b1, 12'(`ADDR_TIME_BASE + 4 * i), {14'h0, ramps[i], d});
  endtask

  // The setpoint is a magnitude; the sign only reaches the direction output.
  function automatic logic [15:0] expMag(input logic signed [15:0] r, input logic [15:0] full);
    logic [31:0] mag;
    mag = 32'(r < 0 ? -r : r) * full / 32'd1000;
    return mag[15:0];
  endfunction

  function automatic logic [31:0] expSpeed(input logic signed [15:0] r, input logic [15:0] full);
    return r < 0 ? 32'h0 - {16'h0, expMag(r, full)} : {16'h0, expMag(r, full)};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(q, 32'h0, "ctrl default");
    apb(1'b1, `ADDR_CTRL, 32'h3);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(q, 32'h0, "undefined end mode");
    apb(1'b0, `ADDR_MAX_FREQ, 32'h0);
    check(q, 32'h1388, "max freq default");
    apb(1'b0, 12'(`ADDR_TIME_BASE + 12'h03C), 32'h0);
    check(q, 32'h0, "duration and ramp default");
    apb(1'b1, 12'(`ADDR_TIME_BASE + 12'h03C), 32'h0003FFFF);
    apb(1'b0, 12'(`ADDR_TIME_BASE + 12'h03C), 32'h0);
    check(q, {14'h0, 2'h3, `DUR_MAX}, "duration clamp");
    apb(1'b1, 12'(`ADDR_REF_BASE + 12'h03C), 32'h00007FFF);
    apb(1'b0, 12'(`ADDR_REF_BASE + 12'h03C), 32'h0);
    check(q, 32'h000003E8, "reference clamp");
    apb(1'b0, 12'h03C, 32'h0);
    check(e, 1'b1, "unmapped read");
    apb(1'b1, `ADDR_STATUS, 32'hFFFF);
    check(e, 1'b1, "read-only write");
    maxF = 16'($random(seed));
    apb(1'b1, `ADDR_MAX_FREQ, {16'h0, maxF});
    for (int i = 0; i < 16; i++) begin
      refs[i] = 16'($random(seed) % 1001);
      ramps[i] = 2'($random(seed));
    end
    refs[0] = -16'sd1000;
    refs[15] = 16'sd1000;
    for (int i = 0; i < 16; i++) apb(1'b1, 12'(`ADDR_REF_BASE + 4 * i), 32'(refs[i]));
    apb(1'b0, `ADDR_REF_BASE, 32'h0);
    check(q, 32'hFFFFFC18, "reference readback");
    progDur(16'd2);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `ADDR_CTRL, 32'(m));
      u_drive.setRun(1'b1);
      check(u_drive.speed, expSpeed(refs[0], maxF), "step 0 speed");
      check(rampSel, ramps[0], "step 0 ramp set");
      repeat (240) @(posedge clk);
      check(driveRun, 1'b1, "pass ended early");
      repeat (360) @(posedge clk);
      status();
      if (m == 0) check({driveRun, s}, {1'b0, ST_IDLE}, "mode stop");
      if (m == 1) check({s, st0}, {ST_HOLD, `LAST_STEP}, "mode hold");
      if (m == 1) check(u_drive.speed, expSpeed(refs[15], maxF), "held speed");
      if (m == 2) check({driveRun, s}, {1'b1, ST_RUN}, "mode repeat");
      u_drive.setRun(1'b0);
    end
    apb(1'b1, `ADDR_CTRL, 32'h10);
    u_drive.setRun(1'b1);
    check({freqSet, voltSet}, {16'h0, 16'h0DC0}, "voltage source");
    repeat (600) @(posedge clk);
    check(driveRun, 1'b1, "voltage source ignores end mode");
    u_drive.setRun(1'b0);
    progDur(16'd20);
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, `ADDR_CTRL, 32'(r << 3));
      u_drive.setRun(1'b1);
      repeat (300) @(posedge clk);
      u_drive.setRun(1'b0);
      status();
      st1 = st0;
      u_drive.setRun(1'b1);
      status();
      check(st0, r ? st1 : `FIRST_STEP, "stop retention");
      u_drive.setRun(1'b0);
    end
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `ADDR_CTRL, 32'(p << 2));
      u_drive.setRun(1'b1);
      repeat (300) @(posedge clk);
      status();
      st1 = st0;
      u_drive.pulse(1'b0);
      u_drive.setRun(1'b0);
      apb(1'b0, `ADDR_PF_SNAP, 32'h0);
      check(q, {12'h0, st1, expMag(refs[st1], maxF)}, "power snapshot");
      u_drive.pulse(1'b1);
      status();
      check(st0, p ? st1 : `FIRST_STEP, "power-up position");
      u_drive.setRun(1'b1);
      status();
      check({s, st0}, {ST_RUN, p ? st1 : `FIRST_STEP}, "resume after power-up");
      u_drive.setRun(1'b0);
    end
    apb(1'b1, `ADDR_CTRL, 32'h20);
    u_drive.setRun(1'b1);
    repeat (400) @(posedge clk);
    status();
    check(st0, `FIRST_STEP, "hour unit");
    u_drive.setRun(1'b0);
    summarize();
  end
endmodule
